/* File: pfj_dead_stage.sv */
// one dead-time insertion and output polarity stage
`timescale 1ns/1ps
`default_nettype none
`include "pfj_defs.svh"

module pfj_dead_stage (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// settings
	input  wire logic        dtEnable,
	input  wire logic [11:0] deadTime,
	input  wire logic        polarity,
	// waveform
	input  wire logic        pwmIn,
	output logic             pwmOut
);
	import pfj_pkg::*;

	pfj_dead_state_type st;
	pfj_dead_state_type next_st;

	// rising edge waits deadTime+1 cycles, falling edge passes at once
	always_comb begin
		next_st = st;
		if (!dtEnable) begin
			next_st.lvl = pwmIn;
			next_st.cnt = `PFJ_RST_ZERO12;
		end else if (!pwmIn) begin
			next_st.lvl = 1'b0;
			next_st.cnt = `PFJ_RST_ZERO12;
		end else if (!st.lvl) begin
			if (st.cnt == deadTime) begin
				next_st.lvl = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 12'h001;
			end
		end
		next_st.pin = next_st.lvl ^ polarity;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pwmOut = st.pin;

endmodule : pfj_dead_stage
`default_nettype wire

/* File: pfj_defs.svh */
// offsets, field positions and reset values of the pwm jitter block
// Operation
// - the 3-bit period/duty step code n moves the period by 2(n+1) counts and the duty by n+1.
// - the 3-bit repeat code n makes the count-mode jitter take n+1 steps in a row.
// - the direction bit steps period and duty up when 0 and down when 1.
// - the 2-bit trigger count of the first dead time waits n+1 triggers per change.
// - bits 6 and 2 of both dead-time jitter registers are absent and read as zero.
// - the 2-bit step of the second dead time changes it by n+1 counts per change.
// - all complementary waveforms come from one 12-bit counter.
// - each of the four outputs has a 12-bit dead-time stage and a polarity stage.
// - an error input either stops the generator at once or lengthens the period.
// - jitter varies frequency and duty periodically, by software or by hardware triggers.
`ifndef PFJ_DEFS_SVH
`define PFJ_DEFS_SVH

// ==========================================
// register offsets
`define PFJ_OFF_CTRL     12'h000
`define PFJ_OFF_PERIOD   12'h004
`define PFJ_OFF_DUTY     12'h008
`define PFJ_OFF_DT0      12'h00C
`define PFJ_OFF_DT1      12'h010
`define PFJ_OFF_PD_JIT   12'h014
`define PFJ_OFF_DT0_JIT  12'h018
`define PFJ_OFF_DT1_JIT  12'h01C
`define PFJ_OFF_STATUS   12'h020
`define PFJ_OFF_PROT_ADJ 12'h024
`define PFJ_OFF_TRIGGER  12'h028

// ==========================================
// control register fields
`define PFJ_CTRL_RUN      0
`define PFJ_CTRL_DT_EN    1
`define PFJ_CTRL_AUTO     2
`define PFJ_CTRL_PROT_ADJ 3
`define PFJ_CTRL_POL_LSB  4
`define PFJ_CTRL_PD_EN    8

// ==========================================
// jitter and status register fields
`define PFJ_PD_DIR        3
`define PFJ_PD_REP_LSB    4
`define PFJ_DTJ_EN        7
`define PFJ_DTJ_DIR       3
`define PFJ_DTJ_CNT_LSB   4
`define PFJ_DTJ_MASK      8'hBB
`define PFJ_STAT_STOP     16
`define PFJ_STAT_FAULT    17

// ==========================================
// reset and limit values
`define PFJ_RST_PERIOD    12'hFFF
`define PFJ_RST_ZERO12    12'h000
`define PFJ_MAX12         12'hFFF
`define PFJ_MIN_PERIOD    12'h001

`endif

/* File: pfj_gate_driver.sv */
// gate driver pair model: reports desaturation, counts shoot-through
`timescale 1ns/1ps
`default_nettype none
module pfj_gate_driver (
	// clock
	input  wire logic        ref_clk,
	// gates and trip command
	input  wire logic [3:0]  pwmOut,
	input  wire logic        tripCmd,
	// reports
	output var logic         faultIn,
	output var logic [15:0]  overlapCount
);
	initial begin
		faultIn = 1'b0;
		overlapCount = 16'h0;
	end
	// the report lags the trip by one cycle, like a slow driver
	always @(posedge ref_clk) begin
		faultIn <= tripCmd;
		if ((pwmOut[0] & pwmOut[1]) | (pwmOut[2] & pwmOut[3])) begin
			overlapCount <= overlapCount + 16'h1;
		end
	end
endmodule : pfj_gate_driver
`default_nettype wire

/* File: pfj_generator.sv */
// complementary pwm generator with count-mode frequency jitter and protection
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pfj_defs.svh"

module pfj_generator (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// register bus
	input  wire pfj_pkg::pfj_apb_req_type apbReq,
	output var  pfj_pkg::pfj_apb_rsp_type apbRsp,
	// protection
	input  wire logic                     faultIn,
	// gate driver outputs
	output logic [3:0]                    pwmOut
);
	import pfj_pkg::*;

	pfj_state_type st;
	pfj_state_type next_st;

	// ==========================================
	// helpers
	function automatic logic [11:0] pfj_adjust(
		input logic [11:0] base,
		input logic [11:0] delta,
		input logic        dec,
		input logic [11:0] lo
	);
		logic [13:0] sum;
		sum = dec ? ({2'b00, base} - {2'b00, delta}) : ({2'b00, base} + {2'b00, delta});
		if (sum[13] || (sum < {2'b00, lo})) begin
			pfj_adjust = lo;
		end else if (sum[12]) begin
			pfj_adjust = `PFJ_MAX12;
		end else begin
			pfj_adjust = sum[11:0];
		end
	endfunction : pfj_adjust

	// ==========================================
	// combinational next state
	logic        run;
	logic        wrap;
	logic        trig;
	logic        fire;
	logic [3:0]  rep;
	logic [3:0]  amtPd;
	logic [3:0]  amtDt;
	logic [7:0]  dPer;
	logic [11:0] perBase;
	logic [11:0] dDt;
	logic        hit;
	logic [31:0] rd;
	logic        accept;
	logic        commit;

	always_comb begin
		next_st = st;
		run     = 1'b0;
		wrap    = 1'b0;
		trig    = 1'b0;
		fire    = 1'b0;
		rep     = 4'h0;
		amtPd   = 4'h0;
		amtDt   = 4'h0;
		dPer    = 8'h00;
		perBase = `PFJ_RST_ZERO12;
		dDt     = `PFJ_RST_ZERO12;
		hit     = 1'b1;
		rd      = 32'h0000_0000;
		accept  = apbReq.psel && apbReq.penable && !st.rsp.pready;
		commit  = apbReq.psel && apbReq.penable && st.rsp.pready;

		// ==========================================
		// error input, two-stage synchroniser
		next_st.faultS1 = faultIn;
		next_st.faultS2 = st.faultS1;
		if (st.faultS2 && st.ctrl[`PFJ_CTRL_RUN] && !st.ctrl[`PFJ_CTRL_PROT_ADJ]) begin
			next_st.stopped = 1'b1;
		end else if (commit && apbReq.pwrite && !st.rsp.pslverr
				&& apbReq.paddr == `PFJ_OFF_STATUS && apbReq.pwdata[`PFJ_STAT_STOP]) begin
			next_st.stopped = 1'b0;
		end

		// ==========================================
		// single counter, shadows reload at wrap
		run  = st.ctrl[`PFJ_CTRL_RUN] && !st.stopped;
		wrap = run && (st.cnt >= st.actPeriod);
		if (!run) begin
			next_st.cnt = `PFJ_RST_ZERO12;
		end else if (wrap) begin
			next_st.cnt = `PFJ_RST_ZERO12;
		end else begin
			next_st.cnt = st.cnt + 12'h001;
		end
		next_st.raw = run && (st.cnt <= st.actDuty);

		if (!run || wrap) begin
			amtPd = {1'b0, st.pdJit[2:0]} + 4'h1;
			dPer  = 8'(8'(st.steps[0]) * 8'(amtPd)) << 1;
			perBase = st.period;
			if (st.faultS2 && st.ctrl[`PFJ_CTRL_PROT_ADJ]) begin
				perBase = pfj_adjust(st.period, st.protAdj, 1'b0, `PFJ_MIN_PERIOD);
			end
			next_st.actPeriod = pfj_adjust(perBase, {4'h0, dPer},
				st.pdJit[`PFJ_PD_DIR], `PFJ_MIN_PERIOD);
			next_st.actDuty = pfj_adjust(st.duty, {5'h00, dPer[7:1]},
				st.pdJit[`PFJ_PD_DIR], `PFJ_RST_ZERO12);
			for (int i = 0; i < 2; i++) begin
				amtDt = {2'b00, st.dtJit[i][1:0]} + 4'h1;
				dDt   = 12'(8'(st.steps[i + 1]) * 8'(amtDt));
				next_st.actDt[i] = pfj_adjust(st.dt[i], dDt,
					st.dtJit[i][`PFJ_DTJ_DIR], `PFJ_RST_ZERO12);
			end
		end

		// ==========================================
		// jitter triggers: hardware at wrap or software write
		trig = (wrap && st.ctrl[`PFJ_CTRL_AUTO])
			|| (commit && apbReq.pwrite && !st.rsp.pslverr
			&& apbReq.paddr == `PFJ_OFF_TRIGGER && apbReq.pwdata[0]);
		rep = {1'b0, st.pdJit[6:4]} + 4'h1;
		for (int c = 0; c < 3; c++) begin
			if (c == 0) begin
				fire = trig && st.ctrl[`PFJ_CTRL_PD_EN];
				if (!st.ctrl[`PFJ_CTRL_PD_EN]) begin
					next_st.steps[c] = 4'h0;
					next_st.back[c]  = 1'b0;
				end
			end else begin
				fire = 1'b0;
				if (!st.dtJit[c - 1][`PFJ_DTJ_EN]) begin
					next_st.steps[c]       = 4'h0;
					next_st.back[c]        = 1'b0;
					next_st.trigDiv[c - 1] = 2'b00;
				end else if (trig) begin
					if (st.trigDiv[c - 1] == st.dtJit[c - 1][5:4]) begin
						fire = 1'b1;
						next_st.trigDiv[c - 1] = 2'b00;
					end else begin
						next_st.trigDiv[c - 1] = st.trigDiv[c - 1] + 2'b01;
					end
				end
			end
			// walk out rep steps, then back to the base value, then repeat
			if (fire) begin
				if (!st.back[c]) begin
					next_st.steps[c] = st.steps[c] + 4'h1;
					next_st.back[c]  = (st.steps[c] + 4'h1) >= rep;
				end else begin
					next_st.steps[c] = st.steps[c] - 4'h1;
					next_st.back[c]  = (st.steps[c] > 4'h1);
				end
			end
		end

		// ==========================================
		// apb slave: one wait state, then pready
		case (apbReq.paddr)
			`PFJ_OFF_CTRL:     rd = {23'h0, st.ctrl};
			`PFJ_OFF_PERIOD:   rd = {20'h0, st.period};
			`PFJ_OFF_DUTY:     rd = {20'h0, st.duty};
			`PFJ_OFF_DT0:      rd = {20'h0, st.dt[0]};
			`PFJ_OFF_DT1:      rd = {20'h0, st.dt[1]};
			`PFJ_OFF_PD_JIT:   rd = {25'h0, st.pdJit};
			`PFJ_OFF_DT0_JIT:  rd = {24'h0, st.dtJit[0] & `PFJ_DTJ_MASK};
			`PFJ_OFF_DT1_JIT:  rd = {24'h0, st.dtJit[1] & `PFJ_DTJ_MASK};
			`PFJ_OFF_STATUS:   rd = {14'h0, st.faultS2, st.stopped, 4'h0, st.actPeriod};
			`PFJ_OFF_PROT_ADJ: rd = {20'h0, st.protAdj};
			`PFJ_OFF_TRIGGER:  rd = 32'h0000_0000;
			default:           hit = 1'b0;
		endcase

		if (accept) begin
			next_st.rsp.pready  = 1'b1;
			next_st.rsp.pslverr = !hit;
			next_st.rsp.prdata  = (hit && !apbReq.pwrite) ? rd : 32'h0000_0000;
		end else begin
			next_st.rsp.pready  = 1'b0;
			next_st.rsp.pslverr = 1'b0;
		end

		if (commit && apbReq.pwrite && !st.rsp.pslverr) begin
			case (apbReq.paddr)
				`PFJ_OFF_CTRL:     next_st.ctrl    = apbReq.pwdata[8:0];
				`PFJ_OFF_PERIOD:   next_st.period  = apbReq.pwdata[11:0];
				`PFJ_OFF_DUTY:     next_st.duty    = apbReq.pwdata[11:0];
				`PFJ_OFF_DT0:      next_st.dt[0]   = apbReq.pwdata[11:0];
				`PFJ_OFF_DT1:      next_st.dt[1]   = apbReq.pwdata[11:0];
				`PFJ_OFF_PD_JIT:   next_st.pdJit   = apbReq.pwdata[6:0];
				`PFJ_OFF_DT0_JIT:  next_st.dtJit[0] = apbReq.pwdata[7:0] & `PFJ_DTJ_MASK;
				`PFJ_OFF_DT1_JIT:  next_st.dtJit[1] = apbReq.pwdata[7:0] & `PFJ_DTJ_MASK;
				`PFJ_OFF_PROT_ADJ: next_st.protAdj = apbReq.pwdata[11:0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st           <= '0;
			st.period    <= `PFJ_RST_PERIOD;
			st.actPeriod <= `PFJ_RST_PERIOD;
		end else begin
			st <= next_st;
		end
	end

	assign apbRsp = st.rsp;

	// ==========================================
	// four output stages: 0 and 2 in phase, 1 and 3 complementary
	for (genvar g = 0; g < 4; g++) begin : gStage
		pfj_dead_stage uStage (
			.ref_clk  (ref_clk),
			.rst      (rst),
			.dtEnable (st.ctrl[`PFJ_CTRL_DT_EN]),
			.deadTime (st.actDt[g % 2]),
			.polarity (st.ctrl[`PFJ_CTRL_POL_LSB + g]),
			.pwmIn    ((g % 2 == 0) ? st.raw : (run && !st.raw)),
			.pwmOut   (pwmOut[g])
		);
	end

endmodule : pfj_generator
`default_nettype wire

/* File: pfj_generator_sva.sv */
// port-level checks of the pwm jitter generator
`timescale 1ns/1ps
`default_nettype none
`include "pfj_defs.svh"
module pfj_generator_sva (
	// clock and reset
	input wire logic                     ref_clk,
	input wire logic                     rst,
	// register bus
	input wire pfj_pkg::pfj_apb_req_type apbReq,
	input wire pfj_pkg::pfj_apb_rsp_type apbRsp,
	// pins
	input wire logic                     faultIn,
	input wire logic [3:0]               pwmOut
);
	import pfj_pkg::*;
	logic acc;
	logic rd;
	assign acc = apbReq.psel & apbReq.penable & ~apbRsp.pready;
	assign rd = apbRsp.pready & ~apbReq.pwrite;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ==========================================
	// handshake
	ready_follow_a: assert property (acc |=> apbRsp.pready)
		else $error("no pready after access");
	ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("pready longer than one cycle");
	ready_cause_a: assert property (apbRsp.pready |-> $past(acc))
		else $error("pready without access");
	// ==========================================
	// decode and data
	err_unmapped_a: assert property (acc && apbReq.paddr > `PFJ_OFF_TRIGGER |=> apbRsp.pslverr)
		else $error("unmapped access not refused");
	err_mapped_a: assert property (acc && apbReq.paddr[1:0] == 2'h0
		&& apbReq.paddr <= `PFJ_OFF_TRIGGER |=> !apbRsp.pslverr)
		else $error("mapped access refused");
	err_data_a: assert property (apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0)
		else $error("error response carries data");
	write_data_a: assert property (apbRsp.pready && apbReq.pwrite |-> apbRsp.prdata == 32'h0)
		else $error("write returned data");
	dtj_bits_a: assert property (
		rd && (apbReq.paddr == `PFJ_OFF_DT0_JIT || apbReq.paddr == `PFJ_OFF_DT1_JIT)
		|-> apbRsp.prdata[31:8] == 24'h0 && !apbRsp.prdata[6] && !apbRsp.prdata[2])
		else $error("absent jitter bits read nonzero");
	reset_quiet_a: assert property (@(posedge ref_clk) disable iff (1'b0)
		rst |=> !apbRsp.pready && pwmOut == 4'h0) else $error("outputs active after reset");
	cover property (apbRsp.pslverr);
	cover property ($rose(pwmOut[0]));
	cover property ($rose(faultIn) ##[1:20] pwmOut[1]);
endmodule : pfj_generator_sva
bind pfj_generator pfj_generator_sva CHK (.ref_clk(ref_clk), .rst(rst), .apbReq(apbReq),
	.apbRsp(apbRsp), .faultIn(faultIn), .pwmOut(pwmOut));
`default_nettype wire

/* File: pfj_pkg.sv */
// types shared by the pwm jitter block
`default_nettype none
package pfj_pkg;

	// ==========================================
	// apb carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pfj_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pfj_apb_rsp_type;

	// ==========================================
	// state of one dead-time and polarity stage
	typedef struct packed {
		logic        pin;
		logic        lvl;
		logic [11:0] cnt;
	} pfj_dead_state_type;

	// ==========================================
	// state of the generator
	typedef struct packed {
		logic [8:0]       ctrl;
		logic [11:0]      period;
		logic [11:0]      duty;
		logic [1:0][11:0] dt;
		logic [6:0]       pdJit;
		logic [1:0][7:0]  dtJit;
		logic [11:0]      protAdj;
		logic [11:0]      cnt;
		logic [11:0]      actPeriod;
		logic [11:0]      actDuty;
		logic [1:0][11:0] actDt;
		logic [2:0][3:0]  steps;
		logic [2:0]       back;
		logic [1:0][1:0]  trigDiv;
		logic             stopped;
		logic             faultS1;
		logic             faultS2;
		logic             raw;
		pfj_apb_rsp_type  rsp;
	} pfj_state_type;

endpackage : pfj_pkg
`default_nettype wire

/* File: pwm_freq_jitter_count_bench.sv */
// self-checking bench of the pwm jitter generator
`timescale 1ns/1ps
`default_nettype none
`include "pfj_defs.svh"
module pwm_freq_jitter_count_bench;
	import pfj_pkg::*;
	logic            ref_clk;
	logic            rst;
	pfj_apb_req_type req;
	pfj_apb_rsp_type apbRsp;
	logic            faultIn;
	logic            tripCmd;
	logic [3:0]      pwmOut;
	logic [15:0]     overlapCount;
	logic [32:0]     expQ[$];
	logic [11:0]     p;
	logic [3:0]      pol;
	int              bad_count;
	int              compares;
	int              seed;
	int              k, i, r, s, d, m, w;
	pfj_generator DUT (.ref_clk(ref_clk), .rst(rst), .apbReq(req), .apbRsp(apbRsp),
		.faultIn(faultIn), .pwmOut(pwmOut));
	pfj_gate_driver DRV (.ref_clk(ref_clk), .pwmOut(pwmOut), .tripCmd(tripCmd),
		.faultIn(faultIn), .overlapCount(overlapCount));
	// ==========================================
	// checking and closing
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	function automatic logic [32:0] st(input logic f, input logic t, input logic [11:0] v);
		return {15'h0, f, t, 4'h0, v};
	endfunction : st
	// ==========================================
	// bus master; every transfer notes its expected answer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
		input logic [32:0] exp);
		int n;
		expQ.push_back(exp);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: v};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 20);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			give_verdict();
		end
		@(posedge ref_clk);
	endtask : apb
	always @(posedge ref_clk) begin
		if (apbRsp.pready === 1'b1) begin
			// an answer nobody asked for can never match this note
			check({apbRsp.pslverr, apbRsp.prdata}, expQ.size() ? expQ.pop_front() : 33'h1FFFFFFFF);
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		give_verdict();
	end
	// ==========================================
	// main sequence
	initial begin
		seed = 59629;
		rst = 1'b1;
		tripCmd = 1'b0;
		req = '0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		apb(1'b0, `PFJ_OFF_PERIOD, 32'h0, 33'h0FFF);
		apb(1'b1, `PFJ_OFF_DT0_JIT, 32'hFF, 33'h0);
		apb(1'b0, `PFJ_OFF_DT0_JIT, 32'h0, 33'hBB);
		apb(1'b1, `PFJ_OFF_DT1_JIT, 32'h44, 33'h0);
		apb(1'b0, `PFJ_OFF_DT1_JIT, 32'h0, 33'h0);
		apb(1'b0, 12'h030, 32'h0, 33'h100000000);
		$display("test registers done");
		apb(1'b1, `PFJ_OFF_DT0, 32'h3, 33'h0);
		apb(1'b1, `PFJ_OFF_DT1, 32'h3, 33'h0);
		apb(1'b1, `PFJ_OFF_PERIOD, 32'h80, 33'h0);
		apb(1'b1, `PFJ_OFF_DUTY, 32'h40, 33'h0);
		apb(1'b1, `PFJ_OFF_CTRL, 32'h103, 33'h0);
		for (k = 0; k < 3; k++) begin
			s = $random(seed) & 7;
			r = $random(seed) & 7;
			d = $random(seed) & 1;
			apb(1'b1, `PFJ_OFF_PD_JIT, 32'((r << 4) | (d << 3) | s), 33'h0);
			for (i = 1; i <= 2 * (r + 1); i++) begin
				apb(1'b1, `PFJ_OFF_TRIGGER, 32'h1, 33'h0);
				repeat (400) @(posedge ref_clk);
				m = (i <= r + 1) ? i : 2 * (r + 1) - i;
				// the period never drops below one count
				p = 12'(d ? ((m * 2 * (s + 1) >= 128) ? 1 : 128 - m * 2 * (s + 1))
					: 128 + m * 2 * (s + 1));
				apb(1'b0, `PFJ_OFF_STATUS, 32'h0, st(1'b0, 1'b0, p));
			end
		end
		check({17'h0, overlapCount}, 33'h0);
		$display("test jitter done");
		pol = 4'($random(seed));
		apb(1'b1, `PFJ_OFF_CTRL, 32'({pol, 4'h1}), 33'h0);
		tripCmd <= 1'b1;
		repeat (10) @(posedge ref_clk);
		check({29'h0, pwmOut}, {29'h0, pol});
		apb(1'b0, `PFJ_OFF_STATUS, 32'h0, st(1'b1, 1'b1, 12'h080));
		tripCmd <= 1'b0;
		repeat (10) @(posedge ref_clk);
		apb(1'b1, `PFJ_OFF_STATUS, 32'h0001_0000, 33'h0);
		apb(1'b0, `PFJ_OFF_STATUS, 32'h0, st(1'b0, 1'b0, 12'h080));
		apb(1'b1, `PFJ_OFF_PROT_ADJ, 32'h10, 33'h0);
		apb(1'b1, `PFJ_OFF_CTRL, 32'h9, 33'h0);
		tripCmd <= 1'b1;
		repeat (400) @(posedge ref_clk);
		apb(1'b0, `PFJ_OFF_STATUS, 32'h0, st(1'b1, 1'b0, 12'h090));
		tripCmd <= 1'b0;
		$display("test protection done");
		// clear leftover dead-time steps, then one step up from a single software trigger
		apb(1'b1, `PFJ_OFF_PD_JIT, 32'h0, 33'h0);
		apb(1'b1, `PFJ_OFF_DT0_JIT, 32'h0, 33'h0);
		s = $random(seed) & 3;
		apb(1'b1, `PFJ_OFF_DT0_JIT, 32'(8'h80 | s), 33'h0);
		apb(1'b1, `PFJ_OFF_CTRL, 32'h3, 33'h0);
		apb(1'b1, `PFJ_OFF_TRIGGER, 32'h1, 33'h0);
		repeat (300) @(posedge ref_clk);
		for (w = 0; w < 400 && pwmOut[1] !== 1'b1; w++) @(posedge ref_clk);
		for (w = 0; w < 400 && pwmOut[1] !== 1'b0; w++) @(posedge ref_clk);
		for (w = 0; w < 400 && pwmOut[0] !== 1'b1; w++) @(posedge ref_clk);
		check(33'(w), 33'(3 + s + 1));
		$display("test dead time done");
		repeat (5) @(posedge ref_clk);
		give_verdict();
	end
endmodule : pwm_freq_jitter_count_bench
`default_nettype wire
